// >>> rtl/shake_detect_and_motion_timers.sv
/*
 * Shake detector with its threshold and duration registers, plus the
 * tilt-35 duration timer and the temporary interrupt latch, both timed by
 * a 10 Hz tick divided down from the system clock.
 * Assumes samples, tilt condition and interrupt requests are synchronous.
 */
// Contract
// RQ1: A shake condition is any axis whose sample-to-sample change exceeds the threshold.
// RQ2: The 16-bit threshold is low byte at 0x46 and high byte at 0x47.
// RQ3: The 12-bit span limit is 0x48 plus bits 3:0 of 0x49.
// RQ4: The 3-bit count limit is bits 6:4 of 0x49, with bit 7 reserved.
// RQ5: The shake decision uses threshold, span limit and count limit together.
// RQ6: A new shake condition increments the counter and starts timing the peak.
// RQ7: Each time the peak outlasts the span limit the counter increments again.
// RQ8: When the condition ends the gap is timed and the counter increments.
// RQ9: Each time the gap outlasts the span limit the counter increments again.
// RQ10: A counter above the count limit sets the shake flag and clears the counter.
// RQ11: Tilt duration and latch period count ticks of the 10 Hz clock.
// RQ12: Tilt code bits 2:0 select 1.6 s plus 0.2 s per step up to 3.0 s.
// RQ13: Latch code bits 6:4 select 200 ms doubling to 6400 ms, upper codes reserved.
// RQ14: Bit 7 of the timer control enables the temporary latch, default off.
// RQ15: A tilt held for the chosen time sets status bit 4.
// RQ16: Durations are terminal tick counts that restart when the condition drops.
`timescale 1ns/100ps
`include "shake_timers_cfg.svh"

module shake_detect_and_motion_timers #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register write port
    input wire shake_timers_pkg::reg_write_t reg_wr,
    // Samples and conditions
    input wire logic sample_valid,
    input wire shake_timers_pkg::accel_sample_t sample,
    input wire logic tilt_cond,
    input wire logic irq_req,
    // Flag clears
    input wire logic shake_flag_clr,
    input wire logic tilt_flag_clr,
    // Results
    output logic [7:0] status_bits,
    output logic test_int
);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ======================================================================
    // Registers
    logic [15:0] shake_delta_limit;
    logic [11:0] peak_span_limit;
    logic [2:0] shake_count_limit;
    logic [7:0] slow_timer_control_r;
    logic latch_hold_enable;

    // RQ2 RQ3 RQ4 register writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shake_delta_limit <= {2{`REG_RESET_VALUE}};
            peak_span_limit <= 12'h000;
            shake_count_limit <= 3'h0;
            slow_timer_control_r <= `REG_RESET_VALUE;
        end else if (reg_wr.en) begin
            if (reg_wr.addr == `OFS_SHAKE_THRESHOLD_LOW) begin
                shake_delta_limit[7:0] <= reg_wr.data;
            end else if (reg_wr.addr == `OFS_SHAKE_THRESHOLD_HIGH) begin
                shake_delta_limit[15:8] <= reg_wr.data;
            end else if (reg_wr.addr == `OFS_PEAK_DURATION_LOW) begin
                peak_span_limit[7:0] <= reg_wr.data;
            end else if (reg_wr.addr == `OFS_PEAK_DURATION_HIGH_AND_COUNT_LIMIT) begin
                peak_span_limit[11:8] <= reg_wr.data[`SPAN_HIGH_MSB:0];
                shake_count_limit <= reg_wr.data[`COUNT_LIMIT_MSB:`COUNT_LIMIT_LSB];
            end else if (reg_wr.addr == `OFS_SLOW_TIMER_CONTROL) begin
                slow_timer_control_r <= reg_wr.data;
            end
        end
    end

    // RQ14 latch enable bit
    assign latch_hold_enable = slow_timer_control_r[`LATCH_ENABLE_BIT];

    // ======================================================================
    // Shake condition
    shake_timers_pkg::accel_sample_t prev_r;
    logic have_prev_r;
    logic shake_cond;

    function automatic logic over_limit(input logic signed [15:0] a,
                                        input logic signed [15:0] b,
                                        input logic [15:0] lim);
        logic signed [16:0] d;
        logic [16:0] mag;
        d = 17'(a) - 17'(b);
        mag = d[16] ? 17'(-d) : 17'(d);
        return mag > {1'b0, lim};
    endfunction : over_limit

    // RQ1 any-axis delta compare
    assign shake_cond = have_prev_r && sample_valid &&
        (over_limit(sample.x, prev_r.x, shake_delta_limit) ||
         over_limit(sample.y, prev_r.y, shake_delta_limit) ||
         over_limit(sample.z, prev_r.z, shake_delta_limit));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
            have_prev_r <= 1'b0;
        end else if (sample_valid) begin
            prev_r <= sample;
            have_prev_r <= 1'b1;
        end
    end

    // ======================================================================
    // Shake sequencer, advanced once per sample
    shake_timers_pkg::shake_state_t state_r, state_nxt;
    logic [11:0] span_r, span_nxt;
    logic [3:0] shk_cnt_r, shk_cnt_nxt;
    logic shake_hit;
    logic shake_flag_r;

    // RQ5 RQ6 RQ7 RQ8 RQ9 sequencer
    always_comb begin
        state_nxt = state_r;
        span_nxt = span_r;
        shk_cnt_nxt = shk_cnt_r;
        if (sample_valid) begin
            case (state_r)
                shake_timers_pkg::SHK_IDLE: begin
                    if (shake_cond) begin
                        state_nxt = shake_timers_pkg::SHK_PEAK;
                        span_nxt = 12'h000;
                        shk_cnt_nxt = shk_cnt_r + 4'h1;
                    end
                end
                shake_timers_pkg::SHK_PEAK: begin
                    if (!shake_cond) begin
                        state_nxt = shake_timers_pkg::SHK_GAP;
                        span_nxt = 12'h000;
                        shk_cnt_nxt = shk_cnt_r + 4'h1;
                    end else if (span_r > peak_span_limit) begin
                        span_nxt = 12'h000;
                        shk_cnt_nxt = shk_cnt_r + 4'h1;
                    end else begin
                        span_nxt = span_r + 12'h001;
                    end
                end
                shake_timers_pkg::SHK_GAP: begin
                    if (shake_cond) begin
                        state_nxt = shake_timers_pkg::SHK_PEAK;
                        span_nxt = 12'h000;
                        shk_cnt_nxt = shk_cnt_r + 4'h1;
                    end else if (span_r > peak_span_limit) begin
                        span_nxt = 12'h000;
                        shk_cnt_nxt = shk_cnt_r + 4'h1;
                    end else begin
                        span_nxt = span_r + 12'h001;
                    end
                end
                default: begin
                    state_nxt = shake_timers_pkg::SHK_IDLE;
                end
            endcase
        end
    end

    // RQ10 count limit reached
    assign shake_hit = shk_cnt_nxt > {1'b0, shake_count_limit};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= shake_timers_pkg::SHK_IDLE;
            span_r <= 12'h000;
            shk_cnt_r <= 4'h0;
        end else if (shake_hit) begin
            state_r <= shake_timers_pkg::SHK_IDLE;
            span_r <= 12'h000;
            shk_cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            span_r <= span_nxt;
            shk_cnt_r <= shk_cnt_nxt;
        end
    end

    // Setting wins over a clear in the same cycle so no shake is lost.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shake_flag_r <= 1'b0;
        end else if (shake_hit) begin
            shake_flag_r <= 1'b1;
        end else if (shake_flag_clr) begin
            shake_flag_r <= 1'b0;
        end
    end

    // ======================================================================
    // 10 Hz tick
    logic [31:0] div_r;
    logic tick;

    // RQ11 low-speed tick divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 32'h0;
        end else if (div_r == 32'(TICK_CYCLES - 1)) begin
            div_r <= 32'h0;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end
    assign tick = div_r == 32'(TICK_CYCLES - 1);

    // ======================================================================
    // Tilt-35 duration
    logic [4:0] tilt_term;
    logic [4:0] tilt_cnt_r;
    logic tilt_flag_r;
    logic tilt_done;

    // RQ12 RQ16 tilt terminal count
    assign tilt_term = 5'(`TILT_BASE_TICKS) +
        5'(`TILT_STEP_TICKS) * {2'b00, slow_timer_control_r[`TILT_CODE_MSB:0]};
    assign tilt_done = tilt_cond && tick && (tilt_cnt_r == tilt_term - 5'h1);

    // RQ16 restart when tilt drops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tilt_cnt_r <= 5'h0;
        end else if (!tilt_cond) begin
            tilt_cnt_r <= 5'h0;
        end else if (tick && tilt_cnt_r < tilt_term) begin
            tilt_cnt_r <= tilt_cnt_r + 5'h1;
        end
    end

    // RQ15 tilt status set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tilt_flag_r <= 1'b0;
        end else if (tilt_done) begin
            tilt_flag_r <= 1'b1;
        end else if (tilt_flag_clr) begin
            tilt_flag_r <= 1'b0;
        end
    end

    always_comb begin
        status_bits = 8'h00;
        status_bits[`STATUS_TILT35_BIT] = tilt_flag_r;
        status_bits[`STATUS_SHAKE_BIT] = shake_flag_r;
    end

    // ======================================================================
    // Temporary latch on the test interrupt output
    logic [2:0] latch_code;
    logic [6:0] latch_term;
    logic [6:0] hold_r;
    logic test_int_r;

    // Reserved codes run as the longest period rather than never releasing.
    // RQ13 latch period select
    assign latch_code = (slow_timer_control_r[`LATCH_CODE_MSB:`LATCH_CODE_LSB] > `LATCH_CODE_MAX) ?
        `LATCH_CODE_MAX : slow_timer_control_r[`LATCH_CODE_MSB:`LATCH_CODE_LSB];
    assign latch_term = 7'(`LATCH_BASE_TICKS) << latch_code;

    // RQ14 RQ11 latch hold in ticks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 7'h0;
            test_int_r <= 1'b0;
        end else if (!latch_hold_enable) begin
            hold_r <= 7'h0;
            test_int_r <= irq_req;
        end else if (hold_r == 7'h0) begin
            hold_r <= irq_req ? latch_term : 7'h0;
            test_int_r <= irq_req;
        end else if (tick) begin
            hold_r <= hold_r - 7'h1;
            test_int_r <= hold_r != 7'h1;
        end
    end
    assign test_int = test_int_r;

    // ======================================================================
    // Checks
    sequence s_thr_low_write;
        reg_wr.en && reg_wr.addr == `OFS_SHAKE_THRESHOLD_LOW;
    endsequence

    property p_thr_low;
        @(posedge clock) disable iff (!rst_n)
        s_thr_low_write |=> shake_delta_limit[7:0] == $past(reg_wr.data);
    endproperty
    a_thr_low: assert property (p_thr_low) else $error("threshold low byte not stored"); // RQ2

    property p_span_high;
        @(posedge clock) disable iff (!rst_n)
        reg_wr.en && reg_wr.addr == `OFS_PEAK_DURATION_HIGH_AND_COUNT_LIMIT |=>
            peak_span_limit[11:8] == $past(reg_wr.data[3:0]);
    endproperty
    a_span_high: assert property (p_span_high) else $error("span high bits wrong"); // RQ3

    property p_cnt_limit;
        @(posedge clock) disable iff (!rst_n)
        reg_wr.en && reg_wr.addr == `OFS_PEAK_DURATION_HIGH_AND_COUNT_LIMIT |=>
            shake_count_limit == $past(reg_wr.data[6:4]);
    endproperty
    a_cnt_limit: assert property (p_cnt_limit) else $error("count limit wrong"); // RQ4

    property p_shake_start;
        @(posedge clock) disable iff (!rst_n)
        state_r == shake_timers_pkg::SHK_IDLE && shake_cond |=>
            state_r == shake_timers_pkg::SHK_PEAK || shake_flag_r;
    endproperty
    a_shake_start: assert property (p_shake_start) else $error("shake not started"); // RQ6

    property p_peak_end;
        @(posedge clock) disable iff (!rst_n)
        state_r == shake_timers_pkg::SHK_PEAK && sample_valid && !shake_cond && !shake_hit
            |=> state_r == shake_timers_pkg::SHK_GAP && shk_cnt_r == $past(shk_cnt_r) + 4'h1;
    endproperty
    a_peak_end: assert property (p_peak_end) else $error("gap not entered"); // RQ8

    property p_hit;
        @(posedge clock) disable iff (!rst_n)
        shk_cnt_nxt > {1'b0, shake_count_limit} |=> shake_flag_r && shk_cnt_r == 4'h0;
    endproperty
    a_hit: assert property (p_hit) else $error("shake flag not set"); // RQ10

    property p_tick_gap;
        @(posedge clock) disable iff (!rst_n)
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close"); // RQ11

    property p_tilt_flag;
        @(posedge clock) disable iff (!rst_n)
        tilt_cond && tick && tilt_cnt_r == tilt_term - 5'h1 |=> status_bits[4];
    endproperty
    a_tilt_flag: assert property (p_tilt_flag) else $error("tilt flag missing"); // RQ15

    property p_tilt_restart;
        @(posedge clock) disable iff (!rst_n)
        !tilt_cond |=> tilt_cnt_r == 5'h0;
    endproperty
    a_tilt_restart: assert property (p_tilt_restart) else $error("tilt count kept"); // RQ16

    property p_latch_off;
        @(posedge clock) disable iff (!rst_n)
        !latch_hold_enable |=> test_int == $past(irq_req);
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("latch not bypassed"); // RQ14

endmodule : shake_detect_and_motion_timers

// >>> rtl/shake_timers_cfg.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * shake detector and the slow motion timers.
 * Assumes a single 100 MHz clock and an 8-bit register write port.
 */
`ifndef SHAKE_TIMERS_CFG_SVH
`define SHAKE_TIMERS_CFG_SVH

// ==========================================================================
// Register offsets
`define OFS_SHAKE_THRESHOLD_LOW 8'h46
`define OFS_SHAKE_THRESHOLD_HIGH 8'h47
`define OFS_PEAK_DURATION_LOW 8'h48
`define OFS_PEAK_DURATION_HIGH_AND_COUNT_LIMIT 8'h49
`define OFS_SLOW_TIMER_CONTROL 8'h4a
`define REG_RESET_VALUE 8'h00

// ==========================================================================
// Field positions
`define SPAN_HIGH_MSB 3
`define COUNT_LIMIT_MSB 6
`define COUNT_LIMIT_LSB 4
`define TILT_CODE_MSB 2
`define LATCH_CODE_MSB 6
`define LATCH_CODE_LSB 4
`define LATCH_ENABLE_BIT 7
`define LATCH_CODE_MAX 3'h5
`define STATUS_TILT35_BIT 4
`define STATUS_SHAKE_BIT 3

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 10
`define LOW_SPEED_PERIOD_NS 100000000
`define TICK_CYCLES (`LOW_SPEED_PERIOD_NS / `CLK_PERIOD_NS)
`define LOW_SPEED_PERIOD_MS 100
`define TILT_BASE_MS 1600
`define TILT_STEP_MS 200
`define LATCH_BASE_MS 200
`define TILT_BASE_TICKS (`TILT_BASE_MS / `LOW_SPEED_PERIOD_MS)
`define TILT_STEP_TICKS (`TILT_STEP_MS / `LOW_SPEED_PERIOD_MS)
`define LATCH_BASE_TICKS (`LATCH_BASE_MS / `LOW_SPEED_PERIOD_MS)

`endif

// >>> rtl/shake_timers_pkg.sv
/*
 * Types shared by the shake detector and its surroundings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package shake_timers_pkg;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } accel_sample_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef enum logic [1:0] {
        SHK_IDLE,
        SHK_PEAK,
        SHK_GAP
    } shake_state_t;

endpackage : shake_timers_pkg

// >>> test/testbench.sv
/*
 * Self-checking testbench for the shake detector and the slow timers.
 * Assumes the design, its package and its configuration header are compiled first.
 */
`timescale 1ns/100ps
`include "shake_timers_cfg.svh"

module testbench;

    // ======================================================================
    // Signals
    localparam int TICK = 8;
    logic clock;
    logic rst_n;
    shake_timers_pkg::reg_write_t reg_wr;
    logic sample_valid;
    shake_timers_pkg::accel_sample_t sample;
    logic tilt_cond;
    logic irq_req;
    logic shake_flag_clr;
    logic tilt_flag_clr;
    logic [7:0] status_bits;
    logic test_int;
    int error_cnt;
    int check_count;
    int cyc;
    int n;
    shake_timers_pkg::accel_sample_t seq_q[$];

    shake_detect_and_motion_timers #(.TICK_CYCLES(TICK)) u_dut (
        .clock(clock),
        .rst_n(rst_n),
        .reg_wr(reg_wr),
        .sample_valid(sample_valid),
        .sample(sample),
        .tilt_cond(tilt_cond),
        .irq_req(irq_req),
        .shake_flag_clr(shake_flag_clr),
        .tilt_flag_clr(tilt_flag_clr),
        .status_bits(status_bits),
        .test_int(test_int)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ======================================================================
    // Reporting
    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_span(input int got, input int lo, input int hi, input string what);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask : check_span

    // ======================================================================
    // Access tasks
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_wr <= '{en: 1'b1, addr: addr, data: data};
        @(posedge clock);
        reg_wr.en <= 1'b0;
    endtask : write_reg

    // One sample per call; the flag is read two edges after it is taken.
    task automatic send(input shake_timers_pkg::accel_sample_t s);
        @(posedge clock);
        sample_valid <= 1'b1;
        sample <= s;
        @(posedge clock);
        sample_valid <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask : send

    function automatic shake_timers_pkg::accel_sample_t mk(input logic [15:0] x,
                                                           input logic [15:0] y,
                                                           input logic [15:0] z);
        return {x, y, z};
    endfunction : mk

    // Counts cycles until the chosen output reaches a level, within a bound.
    task automatic wait_level(input bit use_int, input logic lvl, input int bound);
        cyc = 0;
        do begin
            @(negedge clock);
            cyc++;
            if (cyc > bound) begin
                error_cnt++;
                $display("MISMATCH at %0t: output never reached %b", $time, lvl);
                finish_test();
            end
        end while ((use_int ? test_int : status_bits[`STATUS_TILT35_BIT]) !== lvl);
    endtask : wait_level

    // Threshold 0x0100 and span limit 1 plus limits bits 3:0 as span bits 11:8, then the queued samples after a baseline.
    task automatic shake_seq(input logic [7:0] limits, input int hit);
        do_reset();
        write_reg(`OFS_SHAKE_THRESHOLD_LOW, 8'h00);
        write_reg(`OFS_SHAKE_THRESHOLD_HIGH, 8'h01);
        write_reg(`OFS_PEAK_DURATION_LOW, 8'h01);
        write_reg(`OFS_PEAK_DURATION_HIGH_AND_COUNT_LIMIT, limits);
        write_reg(8'h4e, 8'hff);
        write_reg(8'hc6, 8'hff);
        send(mk(16'h0000, 16'h0000, 16'h0000));
        foreach (seq_q[i]) begin
            send(seq_q[i]);
            check_bit(status_bits[`STATUS_SHAKE_BIT], i >= hit, "shake flag");
        end
        if (hit < seq_q.size()) begin
            @(posedge clock);
            shake_flag_clr <= 1'b1;
            @(posedge clock);
            shake_flag_clr <= 1'b0;
            @(negedge clock);
            check_bit(status_bits[`STATUS_SHAKE_BIT], 1'b0, "cleared shake flag");
        end
    endtask : shake_seq

    // ======================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = '0;
        sample_valid = 1'b0;
        sample = '0;
        tilt_cond = 1'b0;
        irq_req = 1'b0;
        shake_flag_clr = 1'b0;
        tilt_flag_clr = 1'b0;
        error_cnt = 0;
        check_count = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        check_bit(|status_bits, 1'b0, "status after reset");
        check_bit(test_int, 1'b0, "test_int after reset");
        seq_q = '{mk(16'h0100, 16'h0000, 16'h0000), mk(16'h0201, 16'h0000, 16'h0000)};
        shake_seq(8'h00, 1);
        seq_q = '{mk(16'h0000, 16'hfeff, 16'h0000)};
        shake_seq(8'h80, 0);
        seq_q = '{mk(16'h0000, 16'h0000, 16'h0101)};
        shake_seq(8'h00, 0);
        seq_q.delete();
        for (int i = 0; i < 7; i++) begin
            seq_q.push_back(mk((i % 2 == 0) ? 16'h0400 : 16'h0000, 16'h0000, 16'h0000));
        end
        shake_seq(8'h20, 6);
        shake_seq(8'h21, 99);
        seq_q = '{5{mk(16'h0400, 16'h0000, 16'h0000)}};
        shake_seq(8'h20, 4);
        seq_q = '{mk(16'h0400, 16'h0000, 16'h0000), mk(16'h0400, 16'h0000, 16'h0000),
                  mk(16'h0000, 16'h0000, 16'h0000)};
        shake_seq(8'h20, 2);
        for (int c = 0; c < 8; c++) begin
            n = 16 + 2 * c;
            do_reset();
            write_reg(`OFS_SLOW_TIMER_CONTROL, {5'h00, c[2:0]});
            @(posedge clock);
            tilt_cond <= 1'b1;
            repeat ((n - 1) * TICK) @(posedge clock);
            tilt_cond <= 1'b0;
            @(negedge clock);
            check_bit(status_bits[`STATUS_TILT35_BIT], 1'b0, "early tilt flag");
            @(posedge clock);
            tilt_cond <= 1'b1;
            wait_level(1'b0, 1'b1, 40 * TICK);
            check_span(cyc, (n - 1) * TICK + 1, n * TICK + 3, "tilt flag");
            @(posedge clock);
            tilt_cond <= 1'b0;
            tilt_flag_clr <= 1'b1;
            @(posedge clock);
            tilt_flag_clr <= 1'b0;
            @(negedge clock);
            check_bit(status_bits[`STATUS_TILT35_BIT], 1'b0, "cleared tilt flag");
        end
        do_reset();
        @(posedge clock);
        irq_req <= 1'b1;
        @(negedge clock);
        check_bit(test_int, 1'b0, "pass-through early");
        @(posedge clock);
        irq_req <= 1'b0;
        @(negedge clock);
        check_bit(test_int, 1'b1, "pass-through high");
        @(negedge clock);
        check_bit(test_int, 1'b0, "pass-through low");
        for (int c = 0; c < 8; c++) begin
            if (c == 6) begin
                continue;
            end
            n = 2 << ((c > 5) ? 5 : c);
            do_reset();
            write_reg(`OFS_SLOW_TIMER_CONTROL, {1'b1, c[2:0], 4'h0});
            @(posedge clock);
            irq_req <= 1'b1;
            @(posedge clock);
            irq_req <= 1'b0;
            wait_level(1'b1, 1'b1, 3);
            @(posedge clock);
            irq_req <= 1'b1;
            @(posedge clock);
            irq_req <= 1'b0;
            wait_level(1'b1, 1'b0, 70 * TICK);
            check_span(cyc, (n - 1) * TICK, n * TICK + 2, "latch hold");
            @(posedge clock);
            irq_req <= 1'b1;
            @(posedge clock);
            irq_req <= 1'b0;
            wait_level(1'b1, 1'b1, 3);
        end
        finish_test();
    end

endmodule : testbench
